// *** src/counter_channel.sv ***
// one 16-bit down-counter channel, modes 0 to 3, axi4-lite registers
`timescale 1ns/10ps
module counter_channel (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite write
   input wire logic [counter_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [counter_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // channel pins
   input wire logic count_clk_pin,
   input wire logic gate_pin,
   output logic chan_out
);
   import counter_pkg::*;

   typedef struct packed {
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [7:0] w_byte;
      logic w_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] ctrl;
      logic [2:0] mode;
      logic bcd;
      logic [1:0] read_load_select;
      logic [15:0] load;
      logic [15:0] cnt;
      logic out;
      phase_t phase;
      logic hi_next;
      logic armed;
      logic latched;
      logic [15:0] latch_val;
      logic [2:0] clk_sync;
      logic [1:0] gate_sync;
      logic gate_prev;
   } state_t;

   localparam state_t RST = '{
      aw_have: 1'b0, aw_addr: '0, w_have: 1'b0, w_byte: 8'h00,
      w_en: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
      rdata: 32'h0000_0000, rresp: RESP_OKAY, ctrl: CTRL_RESET,
      mode: MODE_RATE, bcd: 1'b0, read_load_select: RL_BOTH,
      load: 16'h0000, cnt: 16'h0000, out: 1'b1, phase: PH_IDLE,
      hi_next: 1'b0, armed: 1'b0, latched: 1'b0, latch_val: 16'h0000,
      clk_sync: 3'h0, gate_sync: 2'h0, gate_prev: 1'b0};

   state_t q, d;
   // one-step decrement, binary or per bcd digit
   function automatic logic [15:0] dec_one(input logic [15:0] v,
                                           input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - 16'h0001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (borrow) begin
               if (r[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : dec_one

   function automatic logic [15:0] dec_by(input logic [15:0] v,
                                          input logic [1:0] step,
                                          input logic bcd);
      logic [15:0] r;
      r = v;
      for (int k = 0; k < 3; k++) begin
         if (2'(k) < step) r = dec_one(r, bcd);
      end
      return r;
   endfunction : dec_by
   logic clk_fall, gate_lvl, gate_rise, gate_fall;
   logic wr_fire, mode_wr, load_wr;
   logic [7:0] wb;
   logic [2:0] new_mode;
   logic [1:0] sq_step;
   // position seven of the source select stops the channel clock
   assign clk_fall = q.clk_sync[2] & ~q.clk_sync[1]
                     & (q.ctrl[CW_SEL_LO +: 3] != SEL_CLK_OFF);
   assign gate_lvl = q.gate_sync[1] & q.ctrl[CW_GATE_EN];
   assign gate_rise = gate_lvl & ~q.gate_prev;
   assign gate_fall = ~gate_lvl & q.gate_prev;
   assign wr_fire = q.aw_have & q.w_have & ~q.bvalid;
   assign wb = q.w_byte;
   assign mode_wr = wr_fire & q.w_en & (q.aw_addr == OFS_MODE);
   assign load_wr = wr_fire & q.w_en & (q.aw_addr == OFS_LOAD);
   assign new_mode = wb[MW_MODE_LO+1] ? {2'b01, wb[MW_MODE_LO]}
                                      : wb[MW_MODE_LO +: 3];
   assign sq_step = ~q.cnt[0] ? STEP_TWO : (q.out ? STEP_ONE : STEP_THREE);

   assign awready = ~q.aw_have & ~q.bvalid;
   assign wready = ~q.w_have & ~q.bvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = ~q.rvalid;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign chan_out = q.out;

   always_comb begin
      d = q;
      d.clk_sync = {q.clk_sync[1:0], count_clk_pin};
      d.gate_sync = {q.gate_sync[0], gate_pin};
      d.gate_prev = gate_lvl;

      // bus slave
      if (awvalid && awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         d.w_have = 1'b1;
         d.w_byte = wdata[7:0];
         d.w_en = wstrb[0];
      end
      if (wr_fire) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (q.aw_addr == OFS_MODE || q.aw_addr == OFS_LOAD ||
                    q.aw_addr == OFS_CTRL) ? RESP_OKAY : RESP_SLVERR;
         if (q.w_en && q.aw_addr == OFS_CTRL) d.ctrl = wb[3:0];
      end
      if (q.bvalid && bready) d.bvalid = 1'b0;
      if (q.rvalid && rready) d.rvalid = 1'b0;
      if (arvalid && arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = 32'h0000_0000;
         unique case (araddr)
            OFS_COUNT: begin
               d.rdata[15:0] = q.latched ? q.latch_val : q.cnt;
               d.latched = 1'b0;
            end
            OFS_STATUS: begin
               d.rdata[10:0] = {q.phase, q.latched, q.read_load_select,
                                q.bcd, q.mode, q.out};
            end
            OFS_CTRL: d.rdata[3:0] = q.ctrl;
            OFS_MODE, OFS_LOAD: d.rdata = 32'h0000_0000;
            default: d.rresp = RESP_SLVERR;
         endcase
      end

      // channel counting on falling clock edges
      if (clk_fall && q.phase == PH_XFER && gate_lvl) begin
         d.cnt = q.load;
         d.phase = PH_RUN;
      end else if (clk_fall && q.phase == PH_RUN) begin
         unique case (q.mode)
            MODE_ONESHOT: begin
               if (gate_lvl) begin
                  d.cnt = dec_one(q.cnt, q.bcd);
                  if (d.cnt == TC_ZERO) d.out = 1'b1;
               end
            end
            MODE_RETRIG: begin
               if (q.armed) begin
                  d.cnt = q.load;
                  d.out = 1'b0;
                  d.armed = 1'b0;
               end else begin
                  d.cnt = dec_one(q.cnt, q.bcd);
                  if (d.cnt == TC_ZERO) d.out = 1'b1;
               end
            end
            MODE_RATE: begin
               if (!gate_lvl || q.cnt == TC_RATE) begin
                  d.cnt = q.load;
                  d.out = 1'b1;
               end else begin
                  // zero preload wraps to full range
                  d.cnt = dec_one(q.cnt, q.bcd);
                  if (d.cnt == TC_RATE) d.out = 1'b0;
               end
            end
            MODE_SQUARE: begin
               if (!gate_lvl) begin
                  d.cnt = q.load;
                  d.out = 1'b1;
               end else if (q.cnt == TC_SQUARE) begin
                  d.cnt = q.load;
                  d.out = ~q.out;
               end else begin
                  d.cnt = dec_by(q.cnt, sq_step, q.bcd);
               end
            end
            default: d.cnt = q.cnt;
         endcase
      end
      if (q.mode == MODE_RATE && gate_fall) d.out = 1'b1;
      if (q.mode == MODE_RETRIG && q.phase == PH_RUN && gate_rise) begin
         d.armed = 1'b1;
      end

      // preload byte writes
      if (load_wr) begin
         unique case (q.read_load_select)
            RL_LSB: d.load = {8'h00, wb};
            RL_MSB: d.load = {wb, 8'h00};
            default: begin
               if (q.hi_next) d.load[15:8] = wb;
               else d.load[7:0] = wb;
            end
         endcase
         if (!q.hi_next && q.mode == MODE_ONESHOT) begin
            d.out = 1'b0;
         end
         if (q.read_load_select == RL_BOTH && !q.hi_next) begin
            d.hi_next = 1'b1;
            d.phase = PH_IDLE;
         end else begin
            d.hi_next = 1'b0;
            d.armed = 1'b0;
            d.phase = (q.mode == MODE_RETRIG) ? PH_RUN : PH_XFER;
         end
      end

      // mode selection
      if (mode_wr) begin
         if (wb[MW_RL_LO +: 2] == RL_LATCH) begin
            d.latched = 1'b1;
            d.latch_val = q.cnt;
         end else begin
            d.mode = new_mode;
            d.bcd = wb[MW_BCD];
            d.read_load_select = wb[MW_RL_LO +: 2];
            d.phase = PH_IDLE;
            d.hi_next = 1'b0;
            d.armed = 1'b0;
            d.latched = 1'b0;
            d.out = (new_mode != MODE_ONESHOT);
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= RST;
      end else if (ce) begin
         q <= d;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic run_edge;
   assign run_edge = ce & clk_fall & (q.phase == PH_RUN) & ~load_wr
                     & ~mode_wr;
   sequence sel_oneshot_s;
      ce && mode_wr && wb[MW_RL_LO +: 2] != RL_LATCH
         && new_mode == MODE_ONESHOT;
   endsequence
   sequence sel_other_s;
      ce && mode_wr && wb[MW_RL_LO +: 2] != RL_LATCH
         && new_mode != MODE_ONESHOT;
   endsequence
   oneshot_select_a: assert property (sel_oneshot_s |=> !chan_out)
      else $error("one-shot select did not drive output low");
   other_select_a: assert property (sel_other_s |=> chan_out)
      else $error("mode select did not drive output high");
   idle_freeze_a: assert property (
      ce && q.phase == PH_IDLE && !mode_wr && !load_wr |=> $stable(q.cnt))
      else $error("count moved before preload complete");
   oneshot_tc_a: assert property (
      run_edge && q.mode == MODE_ONESHOT && gate_lvl && q.cnt == TC_RATE
      |=> chan_out && q.cnt == TC_ZERO)
      else $error("one-shot terminal count missed");
   rate_tc_a: assert property (
      run_edge && q.mode == MODE_RATE && gate_lvl && q.cnt == TC_SQUARE
      |=> !chan_out && q.cnt == TC_RATE)
      else $error("rate pulse did not start");
   rate_reload_a: assert property (
      run_edge && q.mode == MODE_RATE && gate_lvl && q.cnt == TC_RATE
      |=> chan_out && q.cnt == $past(q.load))
      else $error("rate pulse not one period");
   rate_gate_a: assert property (
      run_edge && q.mode == MODE_RATE && !gate_lvl |=> q.cnt == $past(q.load))
      else $error("gate low did not reload");
   square_even_a: assert property (
      run_edge && q.mode == MODE_SQUARE && gate_lvl && !q.cnt[0]
      && q.cnt != TC_SQUARE
      |=> q.cnt == dec_by($past(q.cnt), STEP_TWO, q.bcd))
      else $error("square even step not two");
   retrig_load_a: assert property (
      run_edge && q.mode == MODE_RETRIG && q.armed
      |=> !chan_out && q.cnt == $past(q.load) && !q.armed)
      else $error("trigger did not load and drive low");
   latch_hold_a: assert property (
      ce && mode_wr && wb[MW_RL_LO +: 2] == RL_LATCH
      |=> q.latched && q.latch_val == $past(q.cnt))
      else $error("count latch not taken");
endmodule : counter_channel

// *** shared/counter_pkg.sv ***
// constants for the down-counter channel and its register map
package counter_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_MODE = 5'h00;
   localparam logic [4:0] OFS_LOAD = 5'h04;
   localparam logic [4:0] OFS_COUNT = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0C;
   localparam logic [4:0] OFS_CTRL = 5'h10;
   localparam int ADDR_W = 5;
   // mode word fields
   localparam int MW_BCD = 0;
   localparam int MW_MODE_LO = 1;
   localparam int MW_RL_LO = 4;
   // control word fields
   localparam int CW_GATE_EN = 0;
   localparam int CW_SEL_LO = 1;
   localparam logic [2:0] SEL_CLK_OFF = 3'h7;
   localparam logic [3:0] CTRL_RESET = 4'h1;
   // read/load codes
   localparam logic [1:0] RL_LATCH = 2'h0;
   localparam logic [1:0] RL_LSB = 2'h1;
   localparam logic [1:0] RL_MSB = 2'h2;
   localparam logic [1:0] RL_BOTH = 2'h3;
   // operating modes
   localparam logic [2:0] MODE_ONESHOT = 3'h0;
   localparam logic [2:0] MODE_RETRIG = 3'h1;
   localparam logic [2:0] MODE_RATE = 3'h2;
   localparam logic [2:0] MODE_SQUARE = 3'h3;
   // terminal counts
   localparam logic [15:0] TC_ZERO = 16'h0000;
   localparam logic [15:0] TC_RATE = 16'h0001;
   localparam logic [15:0] TC_SQUARE = 16'h0002;
   // decrement steps
   localparam logic [1:0] STEP_ONE = 2'h1;
   localparam logic [1:0] STEP_TWO = 2'h2;
   localparam logic [1:0] STEP_THREE = 2'h3;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // channel phase
   typedef enum logic [2:0] {
      PH_IDLE = 3'b001,
      PH_XFER = 3'b010,
      PH_RUN = 3'b100
   } phase_t;
endpackage : counter_pkg

// *** verif/pin_source.sv ***
// far-side model driving the channel count clock and gate pins
`timescale 1ns/10ps
module pin_source (
   // system clock
   input wire logic aclk,
   // channel pins
   output logic count_clk_pin,
   output logic gate_pin
);
   // clock stands high between bursts, gate starts enabled
   initial begin
      count_clk_pin = 1'b1;
      gate_pin = 1'b1;
   end
   // n count clock periods, low then high, 6 aclk each
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge aclk);
         count_clk_pin <= 1'b0;
         repeat (6) @(posedge aclk);
         count_clk_pin <= 1'b1;
         repeat (6) @(posedge aclk);
      end
   endtask : pulses
   task automatic set_gate(input logic v);
      @(posedge aclk);
      gate_pin <= v;
      repeat (6) @(posedge aclk);
   endtask : set_gate
endmodule : pin_source

// *** verif/counter_channel_modes_0_to_3_bench.sv ***
// register-level bench for the down-counter channel
`timescale 1ns/10ps
module counter_channel_modes_0_to_3_bench;
   import counter_pkg::*;
   logic aclk, aresetn, ce;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp_val;
   logic count_clk_pin, gate_pin, chan_out;
   int num_errors, num_checks, cycles;

   counter_channel counter_channel_inst (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .count_clk_pin(count_clk_pin), .gate_pin(gate_pin),
      .chan_out(chan_out)
   );
   pin_source pin_source_inst (
      .aclk(aclk), .count_clk_pin(count_clk_pin), .gate_pin(gate_pin)
   );

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic tally_and_finish();
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // run is about 1000 cycles; cut a hang well beyond that
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_bit

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            done = 1'b1;
            resp_val = bresp;
         end
      end
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            done = 1'b1;
            rd_val = rdata;
         end
      end
      rready <= 1'b0;
   endtask : rd

   // count clock periods, then count read (latched value if one is held) and output level
   task automatic step(input int n, input logic [15:0] c, input logic o);
      pin_source_inst.pulses(n);
      rd(OFS_COUNT);
      cmp_word(rd_val, {16'h0000, c});
      cmp_bit(chan_out, o);
   endtask : step

   task automatic out_is(input logic o);
      @(posedge aclk);
      cmp_bit(chan_out, o);
   endtask : out_is

   initial begin
      aresetn = 1'b0;
      ce = 1'b1;
      awaddr = '0;
      araddr = '0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b0;
      rready = 1'b0;
      wdata = 32'h00000000;
      wstrb = 4'hF;
      num_errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(OFS_STATUS);
      cmp_word(rd_val, 32'h00000165);
      rd(OFS_CTRL);
      cmp_word(rd_val, {28'h0000000, CTRL_RESET});
      wr(5'h14, 32'h00000000);
      cmp_word({30'h0, resp_val}, {30'h0, RESP_SLVERR});
      // a write with its low strobe clear is answered but has no effect
      wstrb <= 4'h0;
      wr(OFS_CTRL, 32'h0000000F);
      wstrb <= 4'hF;
      cmp_word({30'h0, resp_val}, {30'h0, RESP_OKAY});
      rd(OFS_CTRL);
      cmp_word(rd_val, {28'h0000000, CTRL_RESET});
      // single count, binary, low byte only
      wr(OFS_MODE, 32'h00000010);
      out_is(1'b0);
      wr(OFS_LOAD, 32'h00000003);
      step(3, 16'h0001, 1'b0);
      step(1, 16'h0000, 1'b1);
      step(2, 16'hFFFE, 1'b1);
      pin_source_inst.set_gate(1'b0);
      step(2, 16'hFFFE, 1'b1);
      pin_source_inst.set_gate(1'b1);
      wr(OFS_LOAD, 32'h00000005);
      out_is(1'b0);
      step(1, 16'h0005, 1'b0);
      // single count in decimal code wraps to 9999
      wr(OFS_MODE, 32'h00000011);
      wr(OFS_LOAD, 32'h00000001);
      step(3, 16'h9999, 1'b1);
      step(1, 16'h9998, 1'b1);
      // rate generator, two-byte preload
      wr(OFS_MODE, 32'h00000034);
      out_is(1'b1);
      wr(OFS_LOAD, 32'h00000003);
      step(2, 16'h9998, 1'b1);
      wr(OFS_LOAD, 32'h00000000);
      step(1, 16'h0003, 1'b1);
      step(1, 16'h0002, 1'b1);
      step(1, 16'h0001, 1'b0);
      step(1, 16'h0003, 1'b1);
      step(1, 16'h0002, 1'b1);
      pin_source_inst.set_gate(1'b0);
      step(1, 16'h0003, 1'b1);
      pin_source_inst.set_gate(1'b1);
      step(2, 16'h0001, 1'b0);
      pin_source_inst.set_gate(1'b0);
      out_is(1'b1);
      pin_source_inst.set_gate(1'b1);
      // square wave; clock source off while preloading
      wr(OFS_CTRL, 32'h0000000F);
      wr(OFS_MODE, 32'h00000016);
      out_is(1'b1);
      wr(OFS_LOAD, 32'h00000004);
      wr(OFS_CTRL, 32'h00000001);
      step(1, 16'h0004, 1'b1);
      step(1, 16'h0002, 1'b1);
      step(1, 16'h0004, 1'b0);
      step(2, 16'h0004, 1'b1);
      // retriggerable one-shot with the gate held off while set up
      wr(OFS_CTRL, 32'h00000000);
      wr(OFS_MODE, 32'h00000012);
      out_is(1'b1);
      wr(OFS_LOAD, 32'h00000005);
      pin_source_inst.set_gate(1'b0);
      wr(OFS_CTRL, 32'h00000001);
      step(1, 16'h0003, 1'b1);
      pin_source_inst.set_gate(1'b1);
      step(1, 16'h0005, 1'b0);
      step(2, 16'h0003, 1'b0);
      pin_source_inst.set_gate(1'b0);
      pin_source_inst.set_gate(1'b1);
      step(1, 16'h0005, 1'b0);
      step(5, 16'h0000, 1'b1);
      step(1, 16'hFFFF, 1'b1);
      // clock enable low freezes the channel through two periods
      ce <= 1'b0;
      pin_source_inst.pulses(2);
      ce <= 1'b1;
      step(0, 16'hFFFF, 1'b1);
      // latch the count while counting carries on
      wr(OFS_MODE, 32'h00000002);
      step(2, 16'hFFFF, 1'b1);
      rd(OFS_COUNT);
      cmp_word(rd_val, 32'h0000FFFD);
      // rate generator with preloads of one and zero
      wr(OFS_MODE, 32'h00000014);
      wr(OFS_LOAD, 32'h00000001);
      step(3, 16'h0001, 1'b1);
      wr(OFS_LOAD, 32'h00000000);
      step(2, 16'hFFFF, 1'b1);
      // square wave with an odd preload
      wr(OFS_MODE, 32'h00000016);
      wr(OFS_LOAD, 32'h00000005);
      step(1, 16'h0005, 1'b1);
      step(1, 16'h0004, 1'b1);
      step(1, 16'h0002, 1'b1);
      step(1, 16'h0005, 1'b0);
      step(1, 16'h0002, 1'b0);
      step(1, 16'h0005, 1'b1);
      // reset in mid-run returns the channel to its idle state
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_STATUS);
      cmp_word(rd_val, 32'h00000165);
      rd(OFS_COUNT);
      cmp_word(rd_val, 32'h00000000);
      cmp_bit(chan_out, 1'b1);
      tally_and_finish();
   end
endmodule : counter_channel_modes_0_to_3_bench
